//--- cgpc_div.sv
/*
 cgpc_div: programmable divider of an enable pulse train.
 Assumes tick_in is a one-cycle pulse on clk; ratio 0 acts as 1.
*/
`timescale 1ns/1ps
`default_nettype none
module cgpc_div
	import cgpc_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic tick_in,
	input wire logic [15:0] ratio,
	output logic tick_out
);
	logic [15:0] cnt_ff;
	logic [15:0] nxt_cnt;
	wire logic wrap;

	// wrap when the next count reaches the ratio
	assign nxt_cnt = cnt_ff + 16'h0001;
	assign wrap = (nxt_cnt >= ratio);

	// one output pulse per ratio input pulses
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			cnt_ff <= 16'h0000;
			tick_out <= 1'b0;
		end
		else
		begin
			tick_out <= tick_in & wrap;
			if (tick_in)
				cnt_ff <= wrap ? 16'h0000 : nxt_cnt;
		end
	end
endmodule
`default_nettype wire

//--- cgpc_osc_model.sv
/*
 cgpc_osc_model: external crystal source and read-strobe strap driver.
 Assumes the bench starts and stops the crystal and sets the strap level.
*/
`timescale 1ns/1ps
`default_nettype none
module cgpc_osc_model
#(
	parameter int HALF = 100
)
(
	input wire logic run,
	input wire logic rd_low,
	output logic crystal_input,
	output logic rd_strobe_n
);
	// a dead oscillator rests low; phase is unrelated to clk on purpose
	initial
	begin
		crystal_input = 1'b0;
		#7;
		forever
		begin
			#(HALF);
			crystal_input = run ? ~crystal_input : 1'b0;
		end
	end
	// the strobe line has a pull-up, so it reads high when released
	assign rd_strobe_n = ~rd_low;
endmodule
`default_nettype wire

//--- cgpc_pkg.sv
/*
 cgpc_pkg: constants of the clock generation and power control block.
 Assumes a single 50 MHz system clock; all derived clocks are enables.
*/
package cgpc_pkg;
	localparam int unsigned CLK_HZ = 50000000;
	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STAT = 8'h04;
	localparam logic [7:0] OFS_PDIS = 8'h08;
	localparam logic [7:0] OFS_PROGRAMMABLE_FREQUENCY_OUTPUT = 8'h0c;
	localparam logic [7:0] OFS_RTC = 8'h10;
	// control register fields
	localparam int CTL_PLL_ON = 0;
	localparam int CTL_BYPASS = 1;
	localparam int CTL_DIV2 = 2;
	localparam int CTL_FAC_LSB = 8;
	localparam int CTL_PRE_LSB = 16;
	localparam logic [31:0] CTRL_RST = 32'h0000_0401;
	// status register fields
	localparam int ST_MISSING = 0;
	localparam int ST_EMERG = 1;
	localparam int ST_MON_ON = 2;
	localparam int ST_PWR_LSB = 3;
	localparam int ST_REQ = 7;
	// frequency output and wake-up fields
	localparam int FO_EN = 0;
	localparam int FO_DIV_LSB = 16;
	localparam logic [31:0] PROGRAMMABLE_FREQUENCY_OUTPUT_RST = 32'h0001_0000;
	localparam int RTC_KEEP = 0;
	localparam int RTC_WAKE_EN = 1;
	localparam int RTC_PER_LSB = 16;
	localparam logic [31:0] RTC_RST = 32'h0100_0000;
	localparam int NPERIPH = 8;
	// free-running pll base frequency, as a divide of clk
	localparam logic [15:0] PLL_BASE_DIV = 16'h0004;
	// base ticks without an oscillator edge before it counts as missing
	localparam logic [7:0] OSC_TIMEOUT = 8'h10;
	localparam logic [1:0] STRAP_WAIT = 2'h3;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	typedef enum logic [3:0] {
		PWR_RUN = 4'h1,
		PWR_IDLE = 4'h2,
		PWR_SLEEP = 4'h4,
		PWR_DOWN = 4'h8
	} cgpc_pwr_e;
endpackage

//--- cgpc_top.sv
/*
 cgpc_top: clock generation, oscillator monitor and power control.
 Assumes an AHB-Lite master on clk, pins that are asynchronous to clk,
 and a CPU that pulses the power instruction inputs for one cycle.
*/
// The implementer's own choices: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// R1: processor/system clock is master clock or half
// R2: master clock feeds CAN and goes out
// R3: master clock from pll multiply or prescaler
// R4: pll runs freely when bypassed, supervising oscillator
// R5: missing oscillator edges raise monitor request
// R6: missing oscillator switches CPU to pll clock
// R7: emergency clock uses basic pll frequency
// R8: pll off disables oscillator monitor
// R9: strap at reset end disables monitor
// R10: power modes entered only by instructions
// R11: idle halts CPU, peripherals keep running
// R12: sleep and power-down stop all clocks; the rtc keeps counting base ticks when RTC_KEEP is set
// R13: external interrupt ends sleep mode
// R14: inactive logic clocks gated automatically
// R15: programmable frequency output pin
// R16: each peripheral individually disabled by software
// R17: real-time clock wakes device periodically
// R18: clock source switch without short pulses
module cgpc_top
	import cgpc_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic crystal_input,
	input wire logic external_access_pin,
	input wire logic rd_strobe_n,
	input wire logic ext_irq,
	input wire logic any_irq,
	input wire logic idle_instr,
	input wire logic sleep_instr,
	input wire logic pdown_instr,
	input wire logic [NPERIPH-1:0] periph_busy,
	output logic master_clock_out,
	output logic master_clk_en,
	output logic can_clk_en,
	output logic processor_clk_en,
	output logic system_clk_en,
	output logic [NPERIPH-1:0] periph_clk_en,
	output logic programmable_frequency_output,
	output logic monitor_irq,
	output logic rtc_wake
);
	logic [31:0] ctrl_ff, pdis_ff, programmable_frequency_output_ff, rtc_ff;
	logic [2:0] xtal_ff;
	logic [1:0] eirq_ff, ea_ff, rd_ff;
	logic [1:0] strap_cnt_ff;
	logic strap_off_ff, missing_ff, emerg_ff, req_ff;
	logic [7:0] mon_cnt_ff;
	logic sel_emerg_ff, sys_pend_ff;
	cgpc_pwr_e pwr_ff, nxt_pwr;
	logic wr_pend_ff;
	logic [7:0] wr_addr_ff;
	wire logic base_tick, mult_tick, pre_tick, src_tick, half_tick;
	wire logic sys_tick, programmable_frequency_output_tick, rtc_tick, osc_edge;
	wire logic mon_on, stopped, acc, wr_ack, req_clr;
	wire logic [7:0] acc_ofs;
	wire logic [31:0] stat_word, rd_word;

	// free-running pll base from its own source, not the crystal
	cgpc_div u_base (.clk(clk), .rst(rst), .tick_in(1'b1), // R4
		.ratio(PLL_BASE_DIV), .tick_out(base_tick));
	// pll multiply: factor sets the output rate
	cgpc_div u_mult (.clk(clk), .rst(rst), .tick_in(1'b1), // R3
		.ratio({8'h00, ctrl_ff[CTL_FAC_LSB +: 8]}), .tick_out(mult_tick));
	// bypass: oscillator edges through the prescaler, 0 = direct drive
	cgpc_div u_pre (.clk(clk), .rst(rst), .tick_in(osc_edge), // R3
		.ratio({8'h00, ctrl_ff[CTL_PRE_LSB +: 8]}), .tick_out(pre_tick));
	// 2:1 prescaler for processor and system clock
	cgpc_div u_half (.clk(clk), .rst(rst), .tick_in(src_tick), // R1
		.ratio(ctrl_ff[CTL_DIV2] ? 16'h0002 : 16'h0001),
		.tick_out(half_tick));
	// frequency output divider, toggles the pin on each pulse
	cgpc_div u_programmable_frequency_output (.clk(clk), .rst(rst), .tick_in(src_tick), // R15
		.ratio(programmable_frequency_output_ff[FO_DIV_LSB +: 16]), .tick_out(programmable_frequency_output_tick));
	// real-time clock runs from the base oscillator, kept if asked
	cgpc_div u_rtc (.clk(clk), .rst(rst),
		.tick_in(base_tick & (!stopped | rtc_ff[RTC_KEEP])), // R12
		.ratio(rtc_ff[RTC_PER_LSB +: 16]), .tick_out(rtc_tick));

	// pin synchronisers; only stage 2 and later are read
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			xtal_ff <= 3'h0;
			eirq_ff <= 2'h0;
			ea_ff <= 2'h0;
			rd_ff <= 2'h3;
		end
		else
		begin
			xtal_ff <= {xtal_ff[1:0], crystal_input};
			eirq_ff <= {eirq_ff[0], ext_irq};
			ea_ff <= {ea_ff[0], external_access_pin};
			rd_ff <= {rd_ff[0], rd_strobe_n};
		end
	end
	assign osc_edge = xtal_ff[1] & !xtal_ff[2];

	// strap sampled once synchronisers settle after reset release
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			strap_cnt_ff <= 2'h0;
			strap_off_ff <= 1'b0;
		end
		else if (strap_cnt_ff != STRAP_WAIT)
		begin
			strap_cnt_ff <= strap_cnt_ff + 2'h1;
			if (strap_cnt_ff == STRAP_WAIT - 2'h1)
				strap_off_ff <= !ea_ff[1] & !rd_ff[1]; // R9
		end
	end

	// monitor only while pll on and bypassed, and not strapped off
	assign mon_on = ctrl_ff[CTL_PLL_ON] & ctrl_ff[CTL_BYPASS] // R8
		& !strap_off_ff; // R9

	// count base ticks since the last oscillator edge
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			mon_cnt_ff <= 8'h00;
			missing_ff <= 1'b0;
		end
		else if (!mon_on || osc_edge)
		begin
			mon_cnt_ff <= 8'h00;
			missing_ff <= 1'b0;
		end
		else if (base_tick && mon_cnt_ff != OSC_TIMEOUT)
		begin
			mon_cnt_ff <= mon_cnt_ff + 8'h01;
			missing_ff <= (mon_cnt_ff + 8'h01 == OSC_TIMEOUT); // R5
		end
	end

	// sticky request: a new loss beats a software clear
	assign req_clr = wr_ack && wr_addr_ff == OFS_STAT && hwdata[ST_REQ];
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			req_ff <= 1'b0;
		else if (missing_ff && !emerg_ff)
			req_ff <= 1'b1; // R5
		else if (req_clr)
			req_ff <= 1'b0;
	end

	// emergency follows the loss; source swap waits for a quiet cycle
	// so no pulse from either source is cut short
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			emerg_ff <= 1'b0;
			sel_emerg_ff <= 1'b0;
		end
		else
		begin
			emerg_ff <= missing_ff; // R6
			if (!base_tick && !mult_tick && !pre_tick)
				sel_emerg_ff <= emerg_ff; // R18
		end
	end

	// emergency runs on the basic pll frequency, not the multiple
	assign src_tick = sel_emerg_ff ? base_tick : // R7
		(ctrl_ff[CTL_BYPASS] ? pre_tick : mult_tick); // R3
	assign sys_tick = half_tick;
	assign stopped = (pwr_ff == PWR_SLEEP) || (pwr_ff == PWR_DOWN);

	// power state: entry by instructions only, never by writes
	always_comb
	begin
		nxt_pwr = pwr_ff;
		case (pwr_ff)
			PWR_RUN:
				if (pdown_instr)
					nxt_pwr = PWR_DOWN; // R10
				else if (sleep_instr)
					nxt_pwr = PWR_SLEEP; // R10
				else if (idle_instr)
					nxt_pwr = PWR_IDLE; // R10
			PWR_IDLE:
				if (any_irq)
					nxt_pwr = PWR_RUN;
			PWR_SLEEP:
				if (eirq_ff[1] ||  // R13
					(rtc_tick && rtc_ff[RTC_WAKE_EN])) // R17
					nxt_pwr = PWR_RUN;
			PWR_DOWN:
				nxt_pwr = PWR_DOWN; // left only by reset
			default:
				nxt_pwr = PWR_RUN;
		endcase
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			pwr_ff <= PWR_RUN;
		else
			pwr_ff <= nxt_pwr;
	end

	// clock enables, all registered; gated when stopped or inactive
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			master_clk_en <= 1'b0;
			can_clk_en <= 1'b0;
			master_clock_out <= 1'b0;
			processor_clk_en <= 1'b0;
			system_clk_en <= 1'b0;
			periph_clk_en <= '0;
			programmable_frequency_output <= 1'b0;
			rtc_wake <= 1'b0;
		end
		else
		begin
			master_clk_en <= src_tick & !stopped; // R2 R12
			can_clk_en <= src_tick & !stopped; // R2
			if (src_tick && !stopped)
				master_clock_out <= !master_clock_out; // R2
			processor_clk_en <= sys_tick & (pwr_ff == PWR_RUN); // R11 R1
			system_clk_en <= sys_tick & !stopped; // R11 R12
			periph_clk_en <= {NPERIPH{sys_tick & !stopped}} // R12
				& periph_busy // R14
				& ~pdis_ff[NPERIPH-1:0]; // R16
			if (!programmable_frequency_output_ff[FO_EN] || stopped)
				programmable_frequency_output <= 1'b0;
			else if (programmable_frequency_output_tick)
				programmable_frequency_output <= // R15
					!programmable_frequency_output;
			rtc_wake <= rtc_tick & rtc_ff[RTC_WAKE_EN]; // R17
		end
	end

	// the request follows the sticky flag to the interrupt node
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			monitor_irq <= 1'b0;
		else
			monitor_irq <= req_ff; // R5
	end

	// bus decode: single word transfers, zero wait states
	assign acc = hsel & hready & (htrans == HTRANS_NONSEQ)
		& (hsize == HSIZE_WORD);
	assign acc_ofs = haddr[7:0];
	assign wr_ack = wr_pend_ff;
	assign stat_word = {24'h000000, req_ff, pwr_ff, mon_on, sel_emerg_ff,
		missing_ff};
	assign rd_word = (acc_ofs == OFS_CTRL) ? ctrl_ff :
		(acc_ofs == OFS_STAT) ? stat_word :
		(acc_ofs == OFS_PDIS) ? pdis_ff :
		(acc_ofs == OFS_PROGRAMMABLE_FREQUENCY_OUTPUT) ? programmable_frequency_output_ff :
		(acc_ofs == OFS_RTC) ? rtc_ff : 32'h0000_0000;

	// address phase: latch write target, prepare read data
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			wr_pend_ff <= 1'b0;
			wr_addr_ff <= 8'h00;
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
		else
		begin
			if (hready)
			begin
				wr_pend_ff <= acc & hwrite;
				wr_addr_ff <= acc_ofs;
			end
			if (acc && !hwrite)
				hrdata <= rd_word;
		end
	end

	// data phase writes; unmapped offsets are ignored
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			ctrl_ff <= CTRL_RST;
			pdis_ff <= 32'h0000_0000;
			programmable_frequency_output_ff <= PROGRAMMABLE_FREQUENCY_OUTPUT_RST;
			rtc_ff <= RTC_RST;
		end
		else if (wr_ack)
		begin
			if (wr_addr_ff == OFS_CTRL)
				ctrl_ff <= hwdata;
			if (wr_addr_ff == OFS_PDIS)
				pdis_ff <= {24'h000000, hwdata[NPERIPH-1:0]}; // R16
			if (wr_addr_ff == OFS_PROGRAMMABLE_FREQUENCY_OUTPUT)
				programmable_frequency_output_ff <= hwdata; // R15
			if (wr_addr_ff == OFS_RTC)
				rtc_ff <= hwdata; // R17
		end
	end

	property p_mon_off;
		@(posedge clk) disable iff (rst)
		!ctrl_ff[CTL_PLL_ON] && !missing_ff |=>
			!missing_ff && !$rose(req_ff);
	endproperty
	a_mon_off: assert property (p_mon_off) else $error("monitor on"); // R8

	property p_loss_req;
		@(posedge clk) disable iff (rst)
		$rose(missing_ff) |-> ##2 monitor_irq;
	endproperty
	a_loss_req: assert property (p_loss_req) else $error("no request"); // R5

	property p_emerg;
		@(posedge clk) disable iff (rst)
		$rose(missing_ff) |-> ##1 emerg_ff ##[0:8] sel_emerg_ff;
	endproperty
	a_emerg: assert property (p_emerg) else $error("no emergency"); // R6

	property p_base;
		@(posedge clk) disable iff (rst)
		sel_emerg_ff && !stopped |=> master_clk_en == $past(base_tick);
	endproperty
	a_base: assert property (p_base) else $error("not base rate"); // R7

	sequence s_idle_entry;
		pwr_ff == PWR_RUN && idle_instr && !sleep_instr && !pdown_instr;
	endsequence
	property p_idle;
		@(posedge clk) disable iff (rst)
		s_idle_entry ##[1:16] (sys_tick && pwr_ff == PWR_IDLE) |=>
			!processor_clk_en && system_clk_en;
	endproperty
	a_idle: assert property (p_idle) else $error("idle gating"); // R11

	property p_stop;
		@(posedge clk) disable iff (rst)
		stopped |=> !master_clk_en && !system_clk_en && !processor_clk_en;
	endproperty
	a_stop: assert property (p_stop) else $error("clock in sleep"); // R12

	property p_wake;
		@(posedge clk) disable iff (rst)
		pwr_ff == PWR_SLEEP && eirq_ff[1] |=> pwr_ff == PWR_RUN;
	endproperty
	a_wake: assert property (p_wake) else $error("no wake"); // R13

	property p_entry;
		@(posedge clk) disable iff (rst)
		$changed(pwr_ff) && pwr_ff != PWR_RUN |->
			$past(idle_instr | sleep_instr | pdown_instr);
	endproperty
	a_entry: assert property (p_entry) else $error("bad entry"); // R10

	property p_pdis;
		@(posedge clk) disable iff (rst)
		(|pdis_ff[NPERIPH-1:0]) |=>
			(periph_clk_en & $past(pdis_ff[NPERIPH-1:0])) == '0;
	endproperty
	a_pdis: assert property (p_pdis) else $error("disabled clock"); // R16

	property p_div2;
		@(posedge clk) disable iff (rst)
		ctrl_ff[CTL_DIV2] && $stable(ctrl_ff) && sys_tick |->
			##1 !sys_tick;
	endproperty
	a_div2: assert property (p_div2) else $error("div2 rate"); // R1
endmodule
`default_nettype wire

//--- cgpc_top_bench.sv
/*
 cgpc_top_bench: self-checking bench of the clock and power block.
 Assumes a 50 MHz clk and a crystal of ten clk periods from the model.
*/
`timescale 1ns/1ps
`default_nettype none
module cgpc_top_bench;
	import cgpc_pkg::*;
	logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, hready;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rdv;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h0;
	logic external_access_pin = 1'b1, run = 1'b1, rd_low = 1'b0;
	logic ext_irq = 1'b0, any_irq = 1'b0, crystal_input, rd_strobe_n;
	logic idle_instr = 1'b0, sleep_instr = 1'b0, pdown_instr = 1'b0;
	logic [7:0] periph_busy = 8'h0, periph_clk_en;
	logic master_clock_out, master_clk_en, can_clk_en, processor_clk_en;
	logic system_clk_en, programmable_frequency_output;
	logic monitor_irq, rtc_wake, hresp;
	int n_fail = 0, checked = 0;
	int c[8];
	// pulse counts in bits 0..5, toggle counts in bits 6..7
	wire logic [7:0] ev = {programmable_frequency_output, master_clock_out,
		|periph_clk_en[2:1], periph_clk_en[0], system_clk_en,
		processor_clk_en, can_clk_en, master_clk_en};

	always #10 clk = ~clk;

	cgpc_top i_cgpc_top (.clk, .rst, .hsel, .haddr, .htrans, .hwrite,
		.hsize, .hwdata, .hready, .hrdata, .hreadyout(hready), .hresp(hresp),
		.crystal_input, .external_access_pin, .rd_strobe_n, .ext_irq,
		.any_irq, .idle_instr, .sleep_instr, .pdown_instr, .periph_busy,
		.master_clock_out, .master_clk_en, .can_clk_en, .processor_clk_en,
		.system_clk_en, .periph_clk_en, .programmable_frequency_output,
		.monitor_irq, .rtc_wake);

	cgpc_osc_model i_cgpc_osc_model (.run, .rd_low, .crystal_input,
		.rd_strobe_n);

	// verdict and end of run, also reached by any timeout
	task automatic report_and_stop;
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e)
		begin
			n_fail++;
			$display("wrong value at %0t: got %h, want %h", $time, g, e);
		end
	endtask

	// bounded wait for a level; running out counts as a mismatch
	task automatic wt(ref logic s, input int lim);
		int k;
		k = 0;
		while (s !== 1'b1 && k < lim)
		begin
			@(posedge clk);
			k++;
		end
		if (s !== 1'b1)
		begin
			n_fail++;
			$display("wrong value at %0t: wait ran out", $time);
			report_and_stop();
		end
	endtask

	// one ahb-lite single word transfer; read data taken at the last edge
	task automatic rw(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= HTRANS_NONSEQ;
		haddr <= {24'h0, a};
		hwrite <= wr;
		hsize <= HSIZE_WORD;
		@(posedge clk);
		wt(hready, 50);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge clk);
		wt(hready, 50);
		rdv = hrdata;
	endtask

	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		rw(1'b0, a, 32'h0);
		chk(rdv, e);
	endtask

	// count enable pulses and output toggles over n cycles
	task automatic cnt(input int n);
		logic [7:0] p;
		c = '{default: 0};
		p = ev;
		repeat (n)
		begin
			@(posedge clk);
			for (int i = 0; i < 8; i++)
				c[i] += (i < 6) ? int'(ev[i]) : int'(ev[i] != p[i]);
			p = ev;
		end
	endtask

	// power instructions are single-cycle pulses
	task automatic pls(input logic [2:0] v);
		{pdown_instr, sleep_instr, idle_instr} <= v;
		@(posedge clk);
		{pdown_instr, sleep_instr, idle_instr} <= 3'h0;
	endtask

	initial
	begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		cnt(3);
		// reset values, unmapped offset, read-only power state
		rc(OFS_CTRL, CTRL_RST);
		rc(OFS_PROGRAMMABLE_FREQUENCY_OUTPUT, PROGRAMMABLE_FREQUENCY_OUTPUT_RST);
		rc(OFS_RTC, RTC_RST);
		rc(OFS_PDIS, 32'h0);
		rw(1'b1, 8'h14, 32'hffff_ffff);
		rc(8'h14, 32'h0);
		chk({31'h0, hresp}, 32'h0);
		rw(1'b1, OFS_STAT, 32'h0000_0020);
		rc(OFS_STAT, 32'h8);
		// pll factor 4 gives a master tick every four cycles
		cnt(400);
		chk(c[0], 100);
		chk(c[1], 100);
		chk(c[6], 100);
		chk(c[2], 100);
		rw(1'b1, OFS_CTRL, 32'h405);
		cnt(20);
		cnt(400);
		chk(c[2], 50);
		chk(c[3], 50);
		rw(1'b1, OFS_CTRL, 32'h801);
		cnt(20);
		cnt(400);
		chk(c[0], 50);
		// direct drive: one master tick per crystal period
		rw(1'b1, OFS_CTRL, 32'h403);
		cnt(20);
		cnt(400);
		chk(c[0], 40);
		rc(OFS_STAT, 32'hc);
		// crystal loss, emergency clock at base rate, then recovery
		run <= 1'b0;
		wt(monitor_irq, 300);
		rc(OFS_STAT, 32'h8f);
		cnt(400);
		chk(c[0], 100);
		run <= 1'b1;
		cnt(60);
		rc(OFS_STAT, 32'h8c);
		rw(1'b1, OFS_STAT, 32'h80);
		cnt(3);
		chk({31'h0, monitor_irq}, 32'h0);
		// pll off silences the monitor
		rw(1'b1, OFS_CTRL, 32'h402);
		run <= 1'b0;
		cnt(300);
		chk({31'h0, monitor_irq}, 32'h0);
		rc(OFS_STAT, 32'h8);
		run <= 1'b1;
		// peripheral gating by activity and by disable bits
		periph_busy <= 8'h05;
		rw(1'b1, OFS_PDIS, 32'h4);
		cnt(20);
		cnt(400);
		chk(c[4], 40);
		chk(c[5], 0);
		rw(1'b1, OFS_PDIS, 32'h0);
		cnt(20);
		cnt(400);
		chk(c[5], 40);
		// frequency output on and off
		rw(1'b1, OFS_PROGRAMMABLE_FREQUENCY_OUTPUT, 32'h0002_0001);
		cnt(20);
		// divide by two of a tick every ten cycles: a toggle every twenty
		cnt(400);
		chk(c[7], 20);
		rw(1'b1, OFS_PROGRAMMABLE_FREQUENCY_OUTPUT, 32'h0002_0000);
		cnt(20);
		cnt(400);
		chk(c[7], 0);
		// idle halts only the processor clock
		pls(3'h1);
		cnt(4);
		rc(OFS_STAT, 32'h10);
		cnt(400);
		chk(c[2], 0);
		chk(c[3], 40);
		any_irq <= 1'b1;
		cnt(3);
		any_irq <= 1'b0;
		rc(OFS_STAT, 32'h8);
		// sleep stops everything until the external interrupt
		pls(3'h2);
		cnt(4);
		rc(OFS_STAT, 32'h20);
		cnt(400);
		chk(c[0], 0);
		chk(c[3], 0);
		ext_irq <= 1'b1;
		cnt(10);
		ext_irq <= 1'b0;
		rc(OFS_STAT, 32'h8);
		// periodic wake from sleep, period of four base ticks
		rw(1'b1, OFS_RTC, 32'h0004_0003);
		pls(3'h2);
		// skip wake pulses launched while still running
		cnt(2);
		wt(rtc_wake, 200);
		cnt(4);
		rc(OFS_STAT, 32'h8);
		rw(1'b1, OFS_RTC, RTC_RST);
		// power-down ignores interrupts; only reset leaves it
		pls(3'h4);
		{ext_irq, any_irq} <= 2'h3;
		cnt(20);
		{ext_irq, any_irq} <= 2'h0;
		rc(OFS_STAT, 32'h40);
		// strap with strobe held low keeps the monitor off
		external_access_pin <= 1'b0;
		rd_low <= 1'b1;
		rst <= 1'b1;
		cnt(20);
		rst <= 1'b0;
		cnt(5);
		rd_low <= 1'b0;
		rw(1'b1, OFS_CTRL, 32'h403);
		rc(OFS_STAT, 32'h8);
		report_and_stop();
	end
endmodule
`default_nettype wire
